// [rtl/bpagu_top.sv]
// Purpose: bit-reversed write addressing and program-space address forming
// Assumes: decoder request arrives on i_clock, registers over AXI4-Lite
// Notes: answer registered one cycle after the request
// Summary of operation
// - bit-reversed mode needs a select other than 15, the enable bit and pre/post increment.
// - a 15-bit reverse modifier sets the pivot, usually half the buffer.
// - reversed addresses are word only, lsb forced low and modifier scaled to bytes.
// - byte accesses and other modes get normal addresses.
// - while active the pointer adds the modifier with reversed carry, ignoring the increment.
// - the modifier is not bit reversed either; it and the pointers stay in normal order.
// - reversal beats modulo in the write unit; modulo stays in the read unit.
// - a 16-entry buffer is visited in mirrored index order.
// - table accesses use table page over the 16-bit address as a 24-bit address.
// - table page bit 7 picks configuration memory over user memory.
// - window accesses form a 23-bit address from the page and low 15 bits, bit 23 low.
// - window address bit 15 comes from page bit 0, not from the data address.
// - the window is read only and gives the low program word only.
// - the window works only while its enable bit in core control is set.
`timescale 1ns/1ps
`include "bpagu_map.svh"
module bpagu_top
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire bpagu_pkg::bpagu_req_t i_req,
    output bpagu_pkg::bpagu_rsp_t o_rsp,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    import bpagu_pkg::*;

    logic [15:0] rev_ctrl_q, rev_ctrl_d;
    logic [15:0] mode_ctrl_q, mode_ctrl_d;
    logic [7:0] tbl_page_q, tbl_page_d;
    logic [7:0] vis_page_q, vis_page_d;
    logic [15:0] core_ctrl_q, core_ctrl_d;
    logic [15:0] rev_count_q, rev_count_d;
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    bpagu_rsp_t rsp_q, rsp_d;
    logic do_write;
    logic rev_active;
    logic inc_mode;
    logic [15:0] rev_next;
    logic [15:0] ea_pre;
    logic [15:0] ea_normal;
    logic [15:0] wnext_normal;
    logic [15:0] ea_now;
    logic pa_valid, pa_table, pa_config, pa_ro;
    logic [23:0] pa_addr;

    // map of known offsets, shared by read and write decode
    function automatic logic known_off(input logic [7:0] a);
        known_off = (a == `BPAGU_OFF_REV_CTRL) || (a == `BPAGU_OFF_MODE_CTRL) ||
            (a == `BPAGU_OFF_TBL_PAGE) || (a == `BPAGU_OFF_VIS_PAGE) ||
            (a == `BPAGU_OFF_CORE_CTRL) || (a == `BPAGU_OFF_STATUS);
    endfunction : known_off

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
        input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // effective address in normal order
    always_comb
    begin
        inc_mode = (i_req.mode == BPAGU_AM_PRE_INC) || (i_req.mode == BPAGU_AM_POST_INC);
        ea_pre = i_req.wptr;
        wnext_normal = i_req.wptr;
        case (i_req.mode)
            BPAGU_AM_POST_INC: wnext_normal = i_req.wptr + i_req.offset;
            BPAGU_AM_POST_DEC: wnext_normal = i_req.wptr - i_req.offset;
            BPAGU_AM_PRE_INC:
            begin
                ea_pre = i_req.wptr + i_req.offset;
                wnext_normal = ea_pre;
            end
            BPAGU_AM_PRE_DEC:
            begin
                ea_pre = i_req.wptr - i_req.offset;
                wnext_normal = ea_pre;
            end
            BPAGU_AM_REG_OFS: ea_pre = i_req.wptr + i_req.offset;
            BPAGU_AM_LIT_OFS: ea_pre = i_req.wptr + i_req.offset;
            default: ea_pre = i_req.wptr;
        endcase
        ea_normal = ea_pre;
    end

    // all three enable conditions, plus word write through the write unit
    assign rev_active = (mode_ctrl_q[`BPAGU_SEL_HI:`BPAGU_SEL_LO] != `BPAGU_SEL_OFF) &&
        rev_ctrl_q[`BPAGU_REV_EN_BIT] && inc_mode &&
        (i_req.wreg == mode_ctrl_q[`BPAGU_SEL_HI:`BPAGU_SEL_LO]) &&
        i_req.write && !i_req.byte_op && !i_req.table_op;

    bpagu_rev_add #(
        .WIDTH(16)
    ) u_rev_add (
        .i_ptr(i_req.wptr),
        .i_modifier(rev_ctrl_q[14:0]),
        .o_next(rev_next)
    );

    // pre-increment uses the reversed sum as address, post uses the pointer
    always_comb
    begin
        ea_now = ea_normal;
        if (rev_active)
        begin
            ea_now = (i_req.mode == BPAGU_AM_PRE_INC) ? rev_next
                : {i_req.wptr[15:1], 1'b0};
        end
    end

    bpagu_prog_addr u_prog_addr (
        .i_table_op(i_req.table_op),
        .i_write(i_req.write),
        .i_win_en(core_ctrl_q[`BPAGU_VIS_EN_BIT]),
        .i_ea(ea_now),
        .i_table_page(tbl_page_q),
        .i_vis_page(vis_page_q),
        .o_valid(pa_valid),
        .o_table(pa_table),
        .o_config(pa_config),
        .o_read_only(pa_ro),
        .o_addr(pa_addr)
    );

    // answer registered so every data output comes from a flip-flop
    always_comb
    begin
        rsp_d = '0;
        rev_count_d = rev_count_q;
        if (i_req.valid)
        begin
            rsp_d.valid = 1'b1;
            rsp_d.ea = ea_now;
            rsp_d.wnext = rev_active ? rev_next : wnext_normal;
            rsp_d.rev_used = rev_active;
            // modulo keeps running for reads, blocked on reversed writes
            rsp_d.mod_allowed = mode_ctrl_q[`BPAGU_MOD_EN_BIT] && !rev_active;
            rsp_d.prog_valid = pa_valid;
            rsp_d.prog_table = pa_table;
            rsp_d.prog_config = pa_config;
            rsp_d.prog_read_only = pa_ro;
            rsp_d.prog_addr = pa_addr;
            if (rev_active)
            begin
                rev_count_d = rev_count_q + 16'h0001;
            end
        end
    end

    // write channel: address and data taken in either order
    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rev_ctrl_d = rev_ctrl_q;
        mode_ctrl_d = mode_ctrl_q;
        tbl_page_d = tbl_page_q;
        vis_page_d = vis_page_q;
        core_ctrl_d = core_ctrl_q;
        do_write = aw_held_q && w_held_q && !bvalid_q;
        if (i_awvalid && o_awready)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            w_held_d = 1'b1;
            w_data_d = i_wdata;
            w_strb_d = i_wstrb;
        end
        if (bvalid_q && i_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (do_write)
        begin
            // response only once both halves are held, one write at a time
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = known_off(aw_addr_q) ? 2'b00 : 2'b10;
            case (aw_addr_q)
                `BPAGU_OFF_REV_CTRL: rev_ctrl_d = merge16(rev_ctrl_q, w_data_q, w_strb_q);
                `BPAGU_OFF_MODE_CTRL: mode_ctrl_d = merge16(mode_ctrl_q, w_data_q, w_strb_q);
                `BPAGU_OFF_TBL_PAGE: tbl_page_d = w_strb_q[0] ? w_data_q[7:0] : tbl_page_q;
                `BPAGU_OFF_VIS_PAGE: vis_page_d = w_strb_q[0] ? w_data_q[7:0] : vis_page_q;
                `BPAGU_OFF_CORE_CTRL: core_ctrl_d = merge16(core_ctrl_q, w_data_q, w_strb_q);
                default: rev_ctrl_d = rev_ctrl_q;
            endcase
        end
    end

    assign o_awready = !aw_held_q;
    assign o_wready = !w_held_q;

    // read channel
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && i_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = known_off(i_araddr) ? 2'b00 : 2'b10;
            case (i_araddr)
                `BPAGU_OFF_REV_CTRL: rdata_d = {16'h0000, rev_ctrl_q};
                `BPAGU_OFF_MODE_CTRL: rdata_d = {16'h0000, mode_ctrl_q};
                `BPAGU_OFF_TBL_PAGE: rdata_d = {24'h000000, tbl_page_q};
                `BPAGU_OFF_VIS_PAGE: rdata_d = {24'h000000, vis_page_q};
                `BPAGU_OFF_CORE_CTRL: rdata_d = {16'h0000, core_ctrl_q};
                `BPAGU_OFF_STATUS: rdata_d = {16'h0000, rev_count_q};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    assign o_arready = !rvalid_q;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            rev_ctrl_q <= `BPAGU_RST_REV;
            mode_ctrl_q <= `BPAGU_RST_MODE;
            tbl_page_q <= `BPAGU_RST_PAGE;
            vis_page_q <= `BPAGU_RST_PAGE;
            core_ctrl_q <= `BPAGU_RST_CORE;
            rev_count_q <= 16'h0000;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
            rsp_q <= '0;
        end
        else
        begin
            rev_ctrl_q <= rev_ctrl_d;
            mode_ctrl_q <= mode_ctrl_d;
            tbl_page_q <= tbl_page_d;
            vis_page_q <= vis_page_d;
            core_ctrl_q <= core_ctrl_d;
            rev_count_q <= rev_count_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            rsp_q <= rsp_d;
        end
    end

    assign o_rsp = rsp_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = rvalid_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;

    AST_REV_GATE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_rsp.rev_used |-> $past(rev_ctrl_q[15]) && $past(inc_mode))
        else $error("reversed mode without enable or increment mode");
    AST_BYTE_NORMAL: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_req.valid && (i_req.byte_op || !i_req.write) |=> !o_rsp.rev_used)
        else $error("reversal on byte access or read");
    AST_LSB_CLEAR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_rsp.rev_used |-> o_rsp.ea[0] == 1'b0 && o_rsp.wnext[0] == 1'b0)
        else $error("reversed address has lsb set");
    AST_MOD_OFF: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_rsp.rev_used |-> !o_rsp.mod_allowed)
        else $error("modulo left on during reversed write");
    AST_REV_SEQ: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_req.valid && rev_active && rev_ctrl_q[14:0] == 15'h0008 && i_req.wptr == 16'h0000
        |=> o_rsp.wnext == 16'h0010)
        else $error("first reversed step wrong for 16 entries");
    AST_TBL_ADDR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_req.valid && i_req.table_op |=> o_rsp.prog_addr == {$past(tbl_page_q), o_rsp.ea})
        else $error("table address not page over ea");
    AST_TBL_CFG: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_rsp.prog_table |-> o_rsp.prog_config == o_rsp.prog_addr[23])
        else $error("configuration select mismatch");
    AST_WIN_ADDR: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        o_rsp.prog_read_only |-> o_rsp.prog_addr[23] == 1'b0 &&
        o_rsp.prog_addr[14:0] == o_rsp.ea[14:0] && o_rsp.prog_addr[15] == $past(vis_page_q[0]))
        else $error("window address formed wrong");
    AST_WIN_EN: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_req.valid && !i_req.table_op && !core_ctrl_q[2] |=> !o_rsp.prog_valid)
        else $error("window used while disabled");
endmodule : bpagu_top

// [rtl/bpagu_map.svh]
// Purpose: offsets, fields and reset values of the address generator
// Assumes: included by the design modules and the bench
// Notes: byte addresses on the register bus
`ifndef BPAGU_MAP_SVH
`define BPAGU_MAP_SVH
`define BPAGU_OFF_REV_CTRL 8'h00
`define BPAGU_OFF_MODE_CTRL 8'h04
`define BPAGU_OFF_TBL_PAGE 8'h08
`define BPAGU_OFF_VIS_PAGE 8'h0c
`define BPAGU_OFF_CORE_CTRL 8'h10
`define BPAGU_OFF_STATUS 8'h14
`define BPAGU_REV_EN_BIT 15
`define BPAGU_SEL_LO 8
`define BPAGU_SEL_HI 11
`define BPAGU_MOD_EN_BIT 15
`define BPAGU_VIS_EN_BIT 2
`define BPAGU_SEL_OFF 4'hf
`define BPAGU_CFG_BIT 7
`define BPAGU_RST_REV 16'h0000
`define BPAGU_RST_MODE 16'h0f00
`define BPAGU_RST_PAGE 8'h00
`define BPAGU_RST_CORE 16'h0000
`endif

// [rtl/bpagu_pkg.sv]
// Purpose: types shared by the address generator
// Assumes: map header supplies the numbers
// Notes: none
package bpagu_pkg;
    typedef enum logic [2:0]
    {
        BPAGU_AM_DIRECT = 3'b000,
        BPAGU_AM_IND = 3'b001,
        BPAGU_AM_POST_INC = 3'b010,
        BPAGU_AM_POST_DEC = 3'b011,
        BPAGU_AM_PRE_INC = 3'b100,
        BPAGU_AM_PRE_DEC = 3'b101,
        BPAGU_AM_REG_OFS = 3'b110,
        BPAGU_AM_LIT_OFS = 3'b111
    } bpagu_amode_t;
    typedef struct packed
    {
        logic valid;
        logic write;
        logic byte_op;
        logic table_op;
        logic [3:0] wreg;
        bpagu_amode_t mode;
        logic [15:0] wptr;
        logic [15:0] offset;
    } bpagu_req_t;
    typedef struct packed
    {
        logic valid;
        logic [15:0] ea;
        logic [15:0] wnext;
        logic rev_used;
        logic mod_allowed;
        logic prog_valid;
        logic prog_table;
        logic prog_config;
        logic prog_read_only;
        logic [23:0] prog_addr;
    } bpagu_rsp_t;
    typedef enum logic [1:0]
    {
        BPAGU_WR_IDLE = 2'b00,
        BPAGU_WR_RESP = 2'b01
    } bpagu_wst_t;
endpackage : bpagu_pkg

// [rtl/bpagu_rev_add.sv]
// Purpose: reversed-carry adder for bit-reversed pointers
// Assumes: word data, bit 0 of the pointer dropped
// Notes: purely combinational
`timescale 1ns/1ps
`include "bpagu_map.svh"
module bpagu_rev_add #(
    parameter int WIDTH = 16
)
(
    input wire logic [WIDTH-1:0] i_ptr,
    input wire logic [WIDTH-2:0] i_modifier,
    output logic [WIDTH-1:0] o_next
);
    logic [WIDTH-1:0] mod_bytes;
    logic [WIDTH-1:0] rp;
    logic [WIDTH-1:0] rm;
    logic [WIDTH-1:0] rs;
    // modifier scaled to byte addresses, pointer lsb forced low
    assign mod_bytes = {i_modifier, 1'b0};
    // bit 0 kept out of the sum so a stray pointer lsb never carries
    assign rp[0] = 1'b0;
    assign rm[0] = 1'b0;
    assign o_next[0] = 1'b0;
    genvar g;
    generate
        for (g = 1; g < WIDTH; g++)
        begin : g_rev
            assign rp[g] = i_ptr[WIDTH-g];
            assign rm[g] = mod_bytes[WIDTH-g];
            assign o_next[g] = rs[WIDTH-g];
        end
    endgenerate
    // carry runs from msb toward lsb: reverse, add, reverse back
    assign rs = rp + rm;
endmodule : bpagu_rev_add

// [rtl/bpagu_prog_addr.sv]
// Purpose: program-space address from a data effective address
// Assumes: table path wins over the visibility window
// Notes: combinational
`timescale 1ns/1ps
`include "bpagu_map.svh"
module bpagu_prog_addr
(
    input wire logic i_table_op,
    input wire logic i_write,
    input wire logic i_win_en,
    input wire logic [15:0] i_ea,
    input wire logic [7:0] i_table_page,
    input wire logic [7:0] i_vis_page,
    output logic o_valid,
    output logic o_table,
    output logic o_config,
    output logic o_read_only,
    output logic [23:0] o_addr
);
    logic win_hit;
    // window is reads only and paused during table accesses
    assign win_hit = !i_table_op && !i_write && i_win_en && i_ea[15];
    always_comb
    begin
        o_addr = 24'h000000;
        o_config = 1'b0;
        if (i_table_op)
        begin
            o_addr = {i_table_page, i_ea};
            o_config = i_table_page[`BPAGU_CFG_BIT];
        end
        else if (win_hit)
        begin
            o_addr = {1'b0, i_vis_page[7:1], i_vis_page[0], i_ea[14:0]};
        end
    end
    assign o_valid = i_table_op || win_hit;
    assign o_table = i_table_op;
    assign o_read_only = win_hit;
endmodule : bpagu_prog_addr

// [test/bpagu_dec_model.sv]
// Purpose: decoder-side model that issues address requests
// Assumes: one request per call, answer one cycle after it is taken
// Notes: valid stands one cycle only, like a real decoder slot
`timescale 1ns/1ps
module bpagu_dec_model
(
    input wire logic i_clock,
    input wire bpagu_pkg::bpagu_rsp_t i_rsp,
    output bpagu_pkg::bpagu_req_t o_req
);
    import bpagu_pkg::*;

    initial o_req = '0;

    // called just after a rising edge; returns just after another
    task automatic send(input bpagu_req_t r, output bpagu_rsp_t s);
        o_req <= r;
        @(posedge i_clock);
        o_req <= '0;
        @(negedge i_clock);
        s = i_rsp;
        @(posedge i_clock);
    endtask : send
endmodule : bpagu_dec_model

// [test/tb_top.sv]
// Purpose: self-checking bench for the address generator
// Assumes: registers over AXI4-Lite, answer one cycle after a request
// Notes: readies sampled at the falling edge, where they are settled
`timescale 1ns/1ps
`include "bpagu_map.svh"
module tb_top;
    import bpagu_pkg::*;
    logic i_clock, i_sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    bpagu_req_t req;
    bpagu_rsp_t rsp, s;
    int fail_count = 0;
    int num_checks = 0;

    bpagu_top i_bpagu_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req(req),
        .o_rsp(rsp), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
        .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
        .o_rdata(rdata), .o_rresp(rresp));
    bpagu_dec_model i_bpagu_dec_model (.i_clock(i_clock), .i_rsp(rsp), .o_req(req));

    initial
    begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(negedge i_clock);
            aw_done = aw_done || (awready === 1'b1);
            w_done = w_done || (wready === 1'b1);
            @(posedge i_clock);
            if (aw_done)
                awvalid <= 1'b0;
            if (w_done)
                wvalid <= 1'b0;
        end
        @(negedge i_clock);
        while (bvalid !== 1'b1)
            @(negedge i_clock);
        resp = bresp;
        @(posedge i_clock);
        bready <= 1'b0;
        @(posedge i_clock);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge i_clock);
        while (arready !== 1'b1)
            @(negedge i_clock);
        @(posedge i_clock);
        arvalid <= 1'b0;
        @(negedge i_clock);
        while (rvalid !== 1'b1)
            @(negedge i_clock);
        rd = rdata;
        resp = rresp;
        @(posedge i_clock);
        rready <= 1'b0;
        @(posedge i_clock);
    endtask : axi_rd

    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    function automatic bpagu_req_t mk(input logic wr, input logic bo, input logic tb,
        input logic [3:0] wn, input bpagu_amode_t m, input logic [15:0] p);
        mk = '{valid: 1'b1, write: wr, byte_op: bo, table_op: tb, wreg: wn, mode: m,
            wptr: p, offset: 16'h0002};
    endfunction : mk

    task automatic test_regs();
        logic [7:0] offs [6];
        logic [31:0] vals [6];
        offs = '{`BPAGU_OFF_REV_CTRL, `BPAGU_OFF_MODE_CTRL, `BPAGU_OFF_TBL_PAGE,
            `BPAGU_OFF_VIS_PAGE, `BPAGU_OFF_CORE_CTRL, `BPAGU_OFF_STATUS};
        vals = '{32'h0, 32'h0f00, 32'h0, 32'h0, 32'h0, 32'h0};
        foreach (offs[k])
        begin
            axi_rd(offs[k]);
            check(rd, vals[k]);
        end
        axi_rd(8'h18);
        check({30'h0, resp}, 32'h2);
        check(rd, 32'h0);
        axi_wr(8'h18, 32'h1234);
        check({30'h0, resp}, 32'h2);
        axi_wr(`BPAGU_OFF_TBL_PAGE, 32'h1ff);
        axi_rd(`BPAGU_OFF_TBL_PAGE);
        check(rd, 32'hff);
        $display("test regs done");
    endtask : test_regs

    task automatic test_rev_seq();
        logic [15:0] p;
        axi_wr(`BPAGU_OFF_MODE_CTRL, 32'h8300);
        axi_wr(`BPAGU_OFF_REV_CTRL, 32'h8008);
        p = 16'h0000; // aligned buffer start, first access a write
        for (int i = 0; i < 16; i++)
        begin
            i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd3, BPAGU_AM_POST_INC, p), s);
            check(32'(s.ea), {27'h0, rev4(4'(i)), 1'b0});
            check(32'(s.rev_used), 32'h1);
            check(32'(s.mod_allowed), 32'h0);
            if (i < 15)
                check(32'(s.wnext), {27'h0, rev4(4'(i + 1)), 1'b0});
            p = s.wnext;
        end
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd3, BPAGU_AM_PRE_INC, 16'h0), s);
        check(32'(s.ea), 32'h10);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd3, BPAGU_AM_POST_INC, 16'h5), s);
        check(32'(s.ea), 32'h4);
        axi_rd(`BPAGU_OFF_STATUS);
        check(rd, 32'h12);
        $display("test rev_seq done");
    endtask : test_rev_seq

    task automatic test_normal();
        bpagu_req_t c [4];
        c[0] = mk(1'b1, 1'b1, 1'b0, 4'd3, BPAGU_AM_POST_INC, 16'h0105);
        c[1] = mk(1'b1, 1'b0, 1'b0, 4'd4, BPAGU_AM_POST_INC, 16'h0104);
        c[2] = mk(1'b1, 1'b0, 1'b0, 4'd3, BPAGU_AM_POST_DEC, 16'h0104);
        c[3] = mk(1'b0, 1'b0, 1'b0, 4'd3, BPAGU_AM_POST_INC, 16'h0104);
        foreach (c[k])
        begin
            i_bpagu_dec_model.send(c[k], s);
            check(32'(s.ea), 32'(c[k].wptr));
            check(32'(s.rev_used), 32'h0);
        end
        axi_wr(`BPAGU_OFF_REV_CTRL, 32'h0008);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd3, BPAGU_AM_POST_INC, 16'h0), s);
        check(32'(s.rev_used), 32'h0);
        check(32'(s.mod_allowed), 32'h1);
        axi_wr(`BPAGU_OFF_REV_CTRL, 32'h8008);
        axi_wr(`BPAGU_OFF_MODE_CTRL, 32'h0f00);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'hf, BPAGU_AM_POST_INC, 16'h0), s);
        check(32'(s.rev_used), 32'h0);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd4, BPAGU_AM_PRE_DEC, 16'h0104), s);
        check(32'(s.ea), 32'h0102);
        check(32'(s.wnext), 32'h0102);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd4, BPAGU_AM_LIT_OFS, 16'h0104), s);
        check(32'(s.ea), 32'h0106);
        check(32'(s.wnext), 32'h0104);
        $display("test normal done");
    endtask : test_normal

    task automatic test_prog();
        axi_wr(`BPAGU_OFF_TBL_PAGE, 32'h85);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b1, 4'd5, BPAGU_AM_IND, 16'h1234), s);
        check(32'(s.prog_addr), 32'h85_1234);
        check(32'(s.prog_config), 32'h1);
        check({s.prog_valid, s.prog_table}, 32'h3);
        check(32'(s.valid), 32'h1);
        axi_wr(`BPAGU_OFF_TBL_PAGE, 32'h05);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b1, 4'd5, BPAGU_AM_IND, 16'h1234), s);
        check(32'(s.prog_addr), 32'h05_1234);
        check(32'(s.prog_config), 32'h0);
        axi_wr(`BPAGU_OFF_VIS_PAGE, 32'h3a);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b0, 4'd5, BPAGU_AM_IND, 16'ha468), s);
        check(32'(s.prog_valid), 32'h0);
        axi_wr(`BPAGU_OFF_CORE_CTRL, 32'h4);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b0, 4'd5, BPAGU_AM_IND, 16'ha468), s);
        check({s.prog_valid, s.prog_table}, 32'h2);
        check(32'(s.prog_addr), {8'h0, 1'b0, 8'h3a, 15'h2468});
        check(32'(s.prog_read_only), 32'h1);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b0, 4'd5, BPAGU_AM_IND, 16'h2468), s);
        check(32'(s.prog_valid), 32'h0);
        i_bpagu_dec_model.send(mk(1'b1, 1'b0, 1'b0, 4'd5, BPAGU_AM_IND, 16'ha468), s);
        check(32'(s.prog_valid), 32'h0);
        i_bpagu_dec_model.send(mk(1'b0, 1'b0, 1'b1, 4'd5, BPAGU_AM_IND, 16'ha468), s);
        check(32'(s.prog_addr), 32'h05_a468);
        check({s.prog_table, s.prog_read_only}, 32'h2);
        $display("test prog done");
    endtask : test_prog

    initial
    begin
        i_sys_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        test_regs();
        test_rev_seq();
        test_normal();
        test_prog();
        conclude();
    end

    // tests need well under a thousand cycles
    initial
    begin
        #(5000 * 20);
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
endmodule : tb_top
